// [sar_adc_defs.svh]
// Offsets, field positions, reset values and timing counts of the converter control
`ifndef SAR_ADC_DEFS_SVH
`define SAR_ADC_DEFS_SVH

// Register byte offsets
`define SAR_OFS_RESULT      12'h000
`define SAR_OFS_CONTROL     12'h004
`define SAR_OFS_IRQ_STATUS  12'h008
`define SAR_OFS_IRQ_MASK    12'h00c

// Control register fields
`define SAR_CTL_CHAN_LSB    0
`define SAR_CTL_CHAN_MSB    1
`define SAR_CTL_DONE_BIT    3
`define SAR_CTL_LADDER_BIT  4

// Interrupt status and mask fields
`define SAR_IRQ_DONE_BIT    0

// Reset values
`define SAR_RST_RESULT      8'h00
`define SAR_RST_CHAN        2'h0
`define SAR_RST_DONE        1'b0
`define SAR_RST_LADDER      1'b0
`define SAR_RST_MASK        1'b0

// Timing
`define SAR_CLK_PERIOD_NS   8
`define SAR_CONV_MAX_NS     12500
`define SAR_CONV_MAX_CYC    (`SAR_CONV_MAX_NS / `SAR_CLK_PERIOD_NS)
`define SAR_SETTLE_NS       64
`define SAR_SETTLE_CYC \
    ((`SAR_SETTLE_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)

`endif

// [sar_adc_pkg.sv]
// Types shared by the converter control logic
`default_nettype none

package sar_adc_pkg;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_CLEAR = 4'b0010,
        ST_SET   = 4'b0100,
        ST_WAIT  = 4'b1000
    } sar_state_e;

    typedef logic [7:0] code_t;

endpackage

`default_nettype wire

// [cmp_sync.sv]
// Three-stage synchroniser with agreement filter for the comparator decision
`default_nettype none

module cmp_sync (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Asynchronous level in, filtered level out
    input  wire logic async_in,
    output var  logic level_r
);

    logic s1_r;
    logic s2_r;
    logic s3_r;

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Change taken once the later two stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_r <= 1'b0;
        end else if (s2_r == s3_r) begin
            level_r <= s3_r;
        end
    end

endmodule

`default_nettype wire

// [sar_adc_control.sv]
// Successive-approximation converter control with APB register access
//
// Overview of operation
// - Result register is read-only to software
// - Control bits 1:0 pick the analog input
// - Unselected analog pins stay general-purpose pins
// - Writing zero to control bit 3 starts
// - Completion flag zero while converting, one after
// - Control bit 4 connects ladder to supply
// - Eight-bit trial code selects ladder reference
// - Start does not clear interrupt request bit
// - Start clears result to zero first
// - Set MSB, drive ladder, sample comparator
// - Keep bit if reference not above input, else clear
// - Conversion done within seventy-three machine cycles
// - Completion sets request, shared bit, flag together
`include "sar_adc_defs.svh"
`default_nettype none

module sar_adc_control
    import sar_adc_pkg::*;
#(
    parameter int ADDR_W     = 12,
    parameter int CHANNELS   = 4,
    parameter int SETTLE_CYC = `SAR_SETTLE_CYC
) (
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output var  logic [31:0]         prdata,
    output var  logic                pready,
    output var  logic                pslverr,
    // Analog front end
    output var  logic [7:0]          trial_code,
    output var  logic [1:0]          chan_sel,
    output var  logic                ladder_en,
    output var  logic [CHANNELS-1:0] analog_pin_en,
    input  wire logic                cmp_ref_above,
    // Interrupt
    output var  logic                irq
);

    localparam logic [7:0] CNT_LAST = 8'(SETTLE_CYC - 1);

    sar_state_e  state_r;
    code_t       result_r;
    code_t       bit_r;
    logic [7:0]  cnt_r;
    logic [1:0]  chan_r;
    logic        done_r;
    logic        ladder_r;
    logic        stat_r;
    logic        mask_r;
    logic        irq_r;
    logic [CHANNELS-1:0] pin_en_r;

    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;

    logic        cmp_lvl;
    logic        setup_ph;
    logic        wr_acc;
    logic        hit_res;
    logic        hit_ctl;
    logic        hit_sts;
    logic        hit_msk;
    logic        mapped;
    logic        start;
    logic        decide;
    logic        finish;
    logic        sts_clr;
    logic        msk_wr;
    logic        stat_nxt;
    logic        mask_nxt;

    // Comparator arrives from the analog side, so it is resynchronised
    cmp_sync u_cmp_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (cmp_ref_above),
        .level_r  (cmp_lvl)
    );

    // Bus decode
    assign setup_ph = psel && !penable;
    assign wr_acc   = psel && penable && pready_r && pwrite && !pslverr_r;
    assign hit_res  = (paddr == ADDR_W'(`SAR_OFS_RESULT));
    assign hit_ctl  = (paddr == ADDR_W'(`SAR_OFS_CONTROL));
    assign hit_sts  = (paddr == ADDR_W'(`SAR_OFS_IRQ_STATUS));
    assign hit_msk  = (paddr == ADDR_W'(`SAR_OFS_IRQ_MASK));
    assign mapped   = hit_res || hit_ctl || hit_sts || hit_msk;

    // Start only on a control write with the flag bit at zero
    assign start = wr_acc && hit_ctl && pstrb[0]
                   && !pwdata[`SAR_CTL_DONE_BIT];

    // Sequencer step points
    assign decide = (state_r == ST_WAIT) && (cnt_r == CNT_LAST);
    assign finish = decide && bit_r[0];

    // Interrupt next values, so the request rises with the status bit
    assign sts_clr  = wr_acc && hit_sts && pstrb[0] && pwdata[`SAR_IRQ_DONE_BIT];
    assign msk_wr   = wr_acc && hit_msk && pstrb[0];
    assign stat_nxt = finish || (stat_r && !sts_clr);
    assign mask_nxt = msk_wr ? pwdata[`SAR_IRQ_DONE_BIT] : mask_r;

    // No wait state: pready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= setup_ph;
        end
    end

    // Unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            pslverr_r <= !mapped;
        end else begin
            pslverr_r <= 1'b0;
        end
    end

    // Read data captured in setup; result read mid-conversion is partial
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_ph && !pwrite) begin
            prdata_r <= 32'h0000_0000;
            if (hit_res) begin
                prdata_r[7:0] <= result_r;
            end
            if (hit_ctl) begin
                prdata_r[`SAR_CTL_CHAN_MSB:`SAR_CTL_CHAN_LSB] <= chan_r;
                prdata_r[`SAR_CTL_DONE_BIT]   <= done_r;
                prdata_r[`SAR_CTL_LADDER_BIT] <= ladder_r;
            end
            if (hit_sts) begin
                prdata_r[`SAR_IRQ_DONE_BIT] <= stat_r;
            end
            if (hit_msk) begin
                prdata_r[`SAR_IRQ_DONE_BIT] <= mask_r;
            end
        end
    end

    // Channel and ladder controls; result register has no write path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_r   <= `SAR_RST_CHAN;
            ladder_r <= `SAR_RST_LADDER;
        end else if (wr_acc && hit_ctl && pstrb[0]) begin
            chan_r   <= pwdata[`SAR_CTL_CHAN_MSB:`SAR_CTL_CHAN_LSB];
            ladder_r <= pwdata[`SAR_CTL_LADDER_BIT];
        end
    end

    // Selected pin switched to the comparator, the rest left to ports
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_pin
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pin_en_r[ch] <= 1'b0;
            end else begin
                pin_en_r[ch] <= (chan_r == 2'(ch));
            end
        end
    end

    // Completion flag: clear on start, set at the final decision
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= `SAR_RST_DONE;
        end else if (start) begin
            done_r <= 1'b0;
        end else if (finish) begin
            done_r <= 1'b1;
        end
    end

    // Sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
        end else if (start) begin
            state_r <= ST_CLEAR; // A new start restarts any conversion
        end else begin
            case (state_r)
                ST_IDLE: begin
                    state_r <= ST_IDLE;
                end
                ST_CLEAR: begin
                    state_r <= ST_SET;
                end
                ST_SET: begin
                    state_r <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (finish) begin
                        state_r <= ST_IDLE;
                    end else if (decide) begin
                        state_r <= ST_SET;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Bit under trial walks from MSB down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_r <= 8'h80;
        end else if (state_r == ST_CLEAR) begin
            bit_r <= 8'h80;
        end else if (decide && !bit_r[0]) begin
            bit_r <= bit_r >> 1;
        end
    end

    // Settle counter covers ladder settling and synchroniser latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 8'h00;
        end else if (state_r == ST_WAIT) begin
            cnt_r <= cnt_r + 8'h01;
        end else begin
            cnt_r <= 8'h00;
        end
    end

    // Result doubles as the trial code driven to the ladder
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_r <= `SAR_RST_RESULT;
        end else if (state_r == ST_CLEAR) begin
            result_r <= 8'h00;
        end else if (state_r == ST_SET) begin
            result_r <= result_r | bit_r;
        end else if (decide && cmp_lvl) begin
            result_r <= result_r & ~bit_r;
        end
    end

    // Sticky request; a completion beats a same-cycle clear.
    // Start leaves it alone, software must clear it itself.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= 1'b0;
        end else if (finish) begin
            stat_r <= 1'b1;
        end else if (sts_clr) begin
            stat_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= `SAR_RST_MASK;
        end else if (msk_wr) begin
            mask_r <= pwdata[`SAR_IRQ_DONE_BIT];
        end
    end

    // Fed from next values: registered, yet no lag behind status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= stat_nxt && mask_nxt;
        end
    end

    // Outputs
    assign prdata        = prdata_r;
    assign pready        = pready_r;
    assign pslverr       = pslverr_r;
    assign trial_code    = result_r;
    assign chan_sel      = chan_r;
    assign ladder_en     = ladder_r;
    assign analog_pin_en = pin_en_r;
    assign irq           = irq_r;

endmodule

`default_nettype wire

// [sar_adc_control_sva.sv]
// Port assertions for the converter control block
`default_nettype none
module sar_adc_control_sva #(parameter int ADDR_W = 12) (
    // Clock, reset, bus
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Front end and interrupt
    input wire logic [7:0]        trial_code,
    input wire logic [1:0]        chan_sel,
    input wire logic              ladder_en,
    input wire logic [3:0]        analog_pin_en,
    input wire logic              irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic acc;
    logic rd;
    logic wr_ctl;
    logic start;
    assign acc    = psel && penable && pready;
    assign rd     = acc && !pwrite;
    assign wr_ctl = acc && pwrite && paddr == ADDR_W'(4);
    assign start  = wr_ctl && !pwdata[3];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    unmapped_err_a: assert property (acc |-> pslverr == (paddr > ADDR_W'(12) || paddr[1:0] != 0))
        else $error("error response wrong");
    result_read_a: assert property (rd && paddr == 0 |->
        prdata == {24'h0, $past(trial_code)})
        else $error("result read wrong");
    ctrl_read_a: assert property (rd && paddr == ADDR_W'(4) |->
        {prdata[31:5], prdata[2]} == 0 && prdata[1:0] == chan_sel && prdata[4] == ladder_en)
        else $error("control read wrong");
    chan_write_a: assert property (wr_ctl |=> chan_sel == $past(pwdata[1:0]))
        else $error("channel not taken");
    ladder_write_a: assert property (wr_ctl |=> ladder_en == $past(pwdata[4]))
        else $error("ladder bit not taken");
    // Pin enables lag the channel by one cycle, so skip the edge of release
    pin_follow_a: assert property ($past(presetn) |->
        analog_pin_en == 4'b1 << $past(chan_sel))
        else $error("pin enable wrong");
    start_clear_a: assert property (start |=>
        ##[0:2] trial_code == 0 ##1 trial_code == 8'h80)
        else $error("start sequence wrong");
    mask_off_a: assert property (acc && pwrite && paddr == ADDR_W'(12) && !pwdata[0] |=>
        !irq [*2])
        else $error("masked irq high");
    cover property (start);
    cover property ($rose(irq));
    cover property (acc && pslverr);
endmodule
bind sar_adc_control sar_adc_control_sva #(.ADDR_W(ADDR_W)) u_sva (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trial_code(trial_code), .chan_sel(chan_sel), .ladder_en(ladder_en),
    .analog_pin_en(analog_pin_en), .irq(irq));
`default_nettype wire

// [afe_model.sv]
// Comparator and resistor ladder front end model
`default_nettype none
module afe_model (
    // Ladder side
    input  wire logic [7:0]  trial_code,
    input  wire logic [1:0]  chan_sel,
    input  wire logic        ladder_en,
    // Pin levels, one code step per unit
    input  wire logic [31:0] pin_levels,
    // Decision
    output var  logic        cmp_ref_above
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lvl;
    assign lvl = pin_levels[chan_sel*8 +: 8];
    // Unpowered ladder gives a zero reference, so the decision reads low
    assign cmp_ref_above = ladder_en && (trial_code > lvl);
endmodule
`default_nettype wire

// [sar_adc_control_tb.sv]
// Self-checking bench for the converter control block
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module sar_adc_control_tb import sar_adc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0;
    logic        presetn = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    code_t       trial_code;
    logic [1:0]  chan_sel;
    logic        ladder_en;
    logic [3:0]  analog_pin_en;
    logic        cmp_ref_above;
    logic        irq;
    code_t       lv [4] = '{default: 8'h00};
    logic [31:0] q;
    logic        e;
    logic [31:0] seed = 77;
    int          bad_count = 0;
    int          num_checks = 0;
    int          cyc = 0;
    time         t0;
    sar_adc_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trial_code(trial_code), .chan_sel(chan_sel),
        .ladder_en(ladder_en), .analog_pin_en(analog_pin_en),
        .cmp_ref_above(cmp_ref_above), .irq(irq));
    afe_model u_afe (.trial_code(trial_code), .chan_sel(chan_sel), .ladder_en(ladder_en),
        .pin_levels({lv[3], lv[2], lv[1], lv[0]}), .cmp_ref_above(cmp_ref_above));
    initial forever #4 pclk = ~pclk;
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            $display("[ERR] %0t timeout", $time);
            bad_count++;
            close_out();
        end
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Read data and error are taken only at the edge that sees pready
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        paddr  <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic conv(input logic [1:0] ch, input logic st);
        apb(12'h004, 1'b1, {27'h0, 3'b100, ch});
        t0 = $time;
        apb(12'h004, 1'b0, 0);
        `CHK(q[4:0], {3'b100, ch});
        apb(12'h008, 1'b0, 0);
        `CHK(q[0], st);
        do apb(12'h004, 1'b0, 0); while (q[3] !== 1'b1);
        `CHK($time - t0 <= 12500, 1'b1);
        apb(12'h000, 1'b0, 0);
        `CHK(q, {24'h0, lv[ch]});
        apb(12'h008, 1'b0, 0);
        `CHK(q, 32'h1);
        `CHK(chan_sel, ch);
        `CHK(analog_pin_en, 4'b0001 << ch);
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 16; a += 4) begin
            apb(12'(a), 1'b0, 0);
            `CHK(q, 32'h0);
        end
        `CHK({irq, analog_pin_en}, 5'h01);
        apb(12'h010, 1'b0, 0);
        `CHK({e, q}, {1'b1, 32'h0});
        apb(12'h000, 1'b1, 32'hff);
        apb(12'h000, 1'b0, 0);
        `CHK(q, 32'h0);
        $display("reset and map test done");
        apb(12'h00c, 1'b1, 1);
        for (int i = 0; i < 6; i++) begin
            lv[i % 4] <= (i == 4) ? 8'hff : (i == 5) ? 8'h00 : code_t'(xs());
            conv(2'(i % 4), i > 0);
        end
        `CHK(irq, 1'b1);
        $display("conversion sweep done");
        apb(12'h008, 1'b1, 1);
        apb(12'h008, 1'b0, 0);
        `CHK({irq, q}, 33'h0);
        apb(12'h00c, 1'b1, 0);
        conv(2'd3, 1'b0);
        `CHK(irq, 1'b0);
        apb(12'h004, 1'b1, 32'h1b);
        apb(12'h004, 1'b0, 0);
        `CHK(q[4:0], 5'h1b);
        apb(12'h004, 1'b1, 32'h0b);
        apb(12'h000, 1'b0, 0);
        `CHK({ladder_en, q}, {1'b0, 24'h0, lv[3]});
        $display("interrupt and ladder test done");
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(12'h004, 1'b0, 0);
        `CHK({ladder_en, q}, 33'h0);
        $display("second reset test done");
        close_out();
    end
endmodule
`default_nettype wire
